// ==== ldc_config_decode.sv ====
/*
 * ldc_config_decode: command decoding, settings and digit scan of a
 * serially programmed four digit seven segment driver.
 * Assumes a serial clock unrelated to core_clk and latches spaced by
 * at least four core clocks.
 */
`timescale 1ns/100ps
`default_nettype none
module ldc_config_decode #(
    parameter int SLOT_CYCLES = ldc_pkg::SLOT_CYC
) (
    // core clock and control
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic core_ce,
    // serial link
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    // display drive
    output logic [3:0] digit_lines_all,
    output logic [6:0] seg_out,
    output logic decimal_point_out
);
    import ldc_pkg::*;

    ldc_word_t link_word;
    ldc_word_t cmd;
    logic link_tog, tog_s1_q, tog_s2_q, tog_seen_q, armed_q, fire;
    logic [3:0] duty_q;
    logic [1:0] digcnt_q;
    logic decode_q;
    logic [7:0] data_q [4];
    ldc_mode_t mode_q;
    logic [$clog2(SLOT_CYCLES+1)-1:0] div_q;
    logic [3:0] slot_q;
    logic [1:0] idx_q;
    logic slot_end, digit_end;
    logic [7:0] cur_data;
    logic [7:0] seg_d;
    logic [3:0] dig_d;
    logic [3:0] en_mask;

    ldc_serial_rx u_rx (
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .ser_latch(ser_latch),
        .word_q(link_word),
        .word_tog_q(link_tog)
    );

    // toggle crossing; the word is stable long before the toggle lands
    always_ff @(posedge core_clk) begin
        tog_s1_q <= link_tog;
        tog_s2_q <= tog_s1_q;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            armed_q <= 1'b0;
            tog_seen_q <= 1'b0;
        end else if (core_ce) begin
            armed_q <= 1'b1;
            tog_seen_q <= tog_s2_q;
        end
    end

    assign fire = core_ce && armed_q && (tog_s2_q != tog_seen_q);
    assign cmd = link_word;

    wire is_load = fire && cmd.sel[7:4] == OP_LOAD;
    wire is_clear = fire && cmd.sel[7:4] == OP_STANDBY && cmd.lo == SB_CLEAR;

    // settings; the host must write valid decode and count together
    always_ff @(posedge core_clk) begin
        if (sys_rst || is_clear) begin
            duty_q <= DUTY_RESET;
            digcnt_q <= DIGCNT_RESET;
            decode_q <= DECODE_RESET;
        end else if (is_load && cmd.sel == SEL_DUTY) begin
            duty_q <= cmd.lo;
        end else if (is_load && cmd.sel == SEL_DECDIG) begin
            // codes above 3H and 2H..FH in bits 7..4 are undefined;
            // the low bits are taken as they stand
            digcnt_q <= cmd.lo[1:0];
            decode_q <= (cmd.hi == HI_DECODE);
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_data
        always_ff @(posedge core_clk) begin
            if (sys_rst || is_clear) begin
                data_q[g] <= DATA_RESET;
            end else if (is_load && cmd.sel == SEL_DATA0 + 8'(g)) begin
                data_q[g] <= {cmd.hi, cmd.lo};
            end
        end
        assign en_mask[g] = (2'(g) <= digcnt_q);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || is_clear) begin
            mode_q <= LDC_BLANK;
        end else if (fire) begin
            unique case (cmd.sel[7:4])
                OP_BLANK: mode_q <= LDC_BLANK;
                OP_NORMAL: mode_q <= LDC_NORMAL;
                OP_ALLON: mode_q <= LDC_ALLON;
                OP_STANDBY: mode_q <= LDC_STANDBY;
                default: mode_q <= mode_q;
            endcase
        end
    end

    // scan: sixteen duty slots per digit, then the next enabled digit
    assign slot_end = (div_q == ($bits(div_q))'(SLOT_CYCLES - 1));
    assign digit_end = slot_end && slot_q == 4'(DUTY_STEPS - 1);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_q <= '0;
            slot_q <= '0;
            idx_q <= '0;
        end else if (core_ce) begin
            div_q <= slot_end ? '0 : div_q + 1'b1;
            if (slot_end) begin
                slot_q <= slot_q + 4'h1;
            end
            if (idx_q > digcnt_q) begin
                idx_q <= '0;
            end else if (digit_end) begin
                idx_q <= (idx_q == digcnt_q) ? 2'h0 : idx_q + 2'h1;
            end
        end
    end

    assign cur_data = data_q[idx_q];

    // small built-in character set: hex digits, blank for 10H..3FH
    function automatic logic [6:0] ldc_char(input logic [5:0] c);
        logic [6:0] s;
        s = 7'h00;
        if (c[5:4] == 2'b00) begin
            unique case (c[3:0])
                4'h0: s = 7'h3f;
                4'h1: s = 7'h06;
                4'h2: s = 7'h5b;
                4'h3: s = 7'h4f;
                4'h4: s = 7'h66;
                4'h5: s = 7'h6d;
                4'h6: s = 7'h7d;
                4'h7: s = 7'h07;
                4'h8: s = 7'h7f;
                4'h9: s = 7'h6f;
                4'ha: s = 7'h77;
                4'hb: s = 7'h7c;
                4'hc: s = 7'h39;
                4'hd: s = 7'h5e;
                4'he: s = 7'h79;
                4'hf: s = 7'h71;
            endcase
        end
        return s;
    endfunction

    always_comb begin
        seg_d = 8'h00;
        dig_d = 4'h0;
        unique case (mode_q)
            LDC_NORMAL: begin
                if (decode_q) begin
                    seg_d = {cur_data[6], ldc_char(cur_data[5:0])};
                end else begin
                    seg_d = cur_data;
                end
                if (slot_q < duty_q && idx_q <= digcnt_q) begin
                    dig_d = 4'h1 << idx_q;
                end
            end
            LDC_ALLON: begin
                seg_d = 8'hff;
                if (slot_q < duty_q && idx_q <= digcnt_q) begin
                    dig_d = 4'h1 << idx_q;
                end
            end
            LDC_BLANK, LDC_STANDBY: begin
                seg_d = 8'h00;
                dig_d = 4'h0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            digit_lines_all <= 4'h0;
            seg_out <= 7'h00;
            decimal_point_out <= 1'b0;
        end else if (core_ce) begin
            digit_lines_all <= dig_d & en_mask;
            seg_out <= seg_d[6:0];
            decimal_point_out <= seg_d[7];
        end
    end

    sequence s_duty_cmd;
        fire && cmd.sel == SEL_DUTY;
    endsequence

    sequence s_clear_cmd;
        is_clear;
    endsequence

    chk_duty_load: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_duty_cmd |=> duty_q == $past(cmd.lo))
        else $error("duty not loaded from low nibble");

    chk_duty_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        (core_ce && $past(core_ce) && digit_lines_all != 4'h0)
            |-> $past(slot_q) < $past(duty_q))
        else $error("digit on outside duty window");

    chk_reset_vals: assert property (@(posedge core_clk)
        sys_rst |=> duty_q == DUTY_RESET && digcnt_q == DIGCNT_RESET
            && decode_q && mode_q == LDC_BLANK)
        else $error("wrong settings after reset");

    chk_clear_vals: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_clear_cmd |=> duty_q == DUTY_RESET && digcnt_q == DIGCNT_RESET
            && decode_q == DECODE_RESET && data_q[0] == DATA_RESET)
        else $error("clear did not restore settings");

    chk_hold_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        !is_load && !is_clear |=> $stable(duty_q) && $stable(digcnt_q)
            && $stable(decode_q))
        else $error("setting changed without command");

    chk_count_load: assert property (@(posedge core_clk) disable iff (sys_rst)
        fire && cmd.sel == SEL_DECDIG |=> digcnt_q == $past(cmd.lo[1:0])
            && decode_q == ($past(cmd.hi) == HI_DECODE))
        else $error("digit count or decode not loaded");

    chk_pass_thru: assert property (@(posedge core_clk) disable iff (sys_rst)
        core_ce && mode_q == LDC_NORMAL && !decode_q
            |=> {decimal_point_out, seg_out} == $past(cur_data))
        else $error("pass-through segments differ from data");

    chk_standby_off: assert property (@(posedge core_clk) disable iff (sys_rst)
        core_ce && mode_q == LDC_STANDBY
            |=> digit_lines_all == 4'h0 && seg_out == 7'h00)
        else $error("outputs on during standby");

    chk_digit_range: assert property (@(posedge core_clk) disable iff (sys_rst)
        core_ce |=> (digit_lines_all & ~$past(en_mask)) == 4'h0)
        else $error("disabled digit line driven");
endmodule // ldc_config_decode
`default_nettype wire

// ==== ldc_pkg.sv ====
/*
 * ldc_pkg: shared constants and types of the led driver configuration
 * decoder. Assumes nothing beyond a SystemVerilog compiler.
 */
package ldc_pkg;
    // 16-bit command word as shifted in over the serial port
    typedef struct packed {
        logic [7:0] sel;
        logic [3:0] hi;
        logic [3:0] lo;
    } ldc_word_t;

    typedef enum logic [1:0] {
        LDC_BLANK, LDC_NORMAL, LDC_ALLON, LDC_STANDBY
    } ldc_mode_t;

    localparam int WORD_W = 16;
    localparam logic [3:0] OP_BLANK = 4'h0;
    localparam logic [3:0] OP_NORMAL = 4'h1;
    localparam logic [3:0] OP_LOAD = 4'h2;
    localparam logic [3:0] OP_ALLON = 4'h3;
    localparam logic [3:0] OP_STANDBY = 4'h4;
    localparam logic [7:0] SEL_DUTY = 8'h20;
    localparam logic [7:0] SEL_DECDIG = 8'h21;
    localparam logic [7:0] SEL_DATA0 = 8'h22;
    localparam logic [7:0] SEL_DATA3 = 8'h25;
    localparam logic [3:0] SB_ENTER = 4'h0;
    localparam logic [3:0] SB_CLEAR = 4'h1;
    localparam logic [3:0] HI_NODECODE = 4'h0;
    localparam logic [3:0] HI_DECODE = 4'h1;

    localparam logic [3:0] DUTY_RESET = 4'hf;
    localparam logic [1:0] DIGCNT_RESET = 2'h3;
    localparam logic DECODE_RESET = 1'b1;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam int DUTY_STEPS = 16;

    // one duty slot of the scan
    localparam int CLK_PERIOD_NS = 25;
    localparam int SLOT_TIME_NS = 1000;
    localparam int SLOT_CYC = SLOT_TIME_NS / CLK_PERIOD_NS;
endpackage

// ==== ldc_serial_rx.sv ====
/*
 * ldc_serial_rx: shift register on the serial clock. Assumes the host
 * holds the latch high for one serial clock edge after the 16 data bits,
 * and leaves several core clocks between latches.
 */
`timescale 1ns/100ps
`default_nettype none
module ldc_serial_rx (
    // serial link
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    // to core domain
    output ldc_pkg::ldc_word_t word_q,
    output logic word_tog_q
);
    import ldc_pkg::*;

    logic [WORD_W-1:0] shift_q;
    // known power-up level only; the core primes its detector from
    // whatever it finds, but an unknown toggle would never resolve
    logic tog_q = 1'b0;

    // no reset here: the link clock may stand still, the core primes
    // its toggle detector from whatever level it finds
    always_ff @(posedge ser_clk) begin
        if (!ser_latch) begin
            shift_q <= {shift_q[WORD_W-2:0], ser_data};
        end
    end

    always_ff @(posedge ser_clk) begin
        if (ser_latch) begin
            word_q <= shift_q;
            tog_q <= ~tog_q;
        end
    end

    assign word_tog_q = tog_q;
endmodule // ldc_serial_rx
`default_nettype wire

// ==== ldc_host_model.sv ====
/*
 * ldc_host_model: host side of the serial command port, sends whole
 * 16-bit words msb first. Assumes the caller spaces words itself.
 */
`timescale 1ns/100ps
`default_nettype none
module ldc_host_model (
    // serial link to the device
    output var logic ser_clk,
    output var logic ser_data,
    output var logic ser_latch
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_latch = 1'b0;
    end

    // clock stands still low between frames; data held across each rise
    task automatic send(input logic [15:0] w);
        // offset keeps serial edges off the core clock edges
        #10;
        for (int i = 15; i >= 0; i--) begin
            ser_data = w[i];
            #62.5 ser_clk = 1'b1;
            #62.5 ser_clk = 1'b0;
        end
        ser_latch = 1'b1;
        #62.5 ser_clk = 1'b1;
        #62.5 ser_clk = 1'b0;
        ser_latch = 1'b0;
        // released line shows the inverse, never a stale level
        ser_data = ~w[0];
    endtask
endmodule // ldc_host_model
`default_nettype wire

// ==== ldc_config_decode_test.sv ====
/*
 * ldc_config_decode_test: self-checking bench for the decoder.
 * Assumes the host model above and a short scan slot of 2 clocks.
 */
`timescale 1ns/100ps
`default_nettype none
module ldc_config_decode_test;
    import ldc_pkg::*;
    localparam int SLOTS = 2;
    // window spans whole scans for one to four digits
    localparam int WIN = 384;
    typedef struct packed {
        logic [15:0] word;
        logic [3:0] duty;
        logic [1:0] cnt;
        logic run;
        logic pass;
        logic [7:0] seg;
    } ldc_row_t;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic core_ce = 1'b1;
    wire ser_clk;
    wire ser_data;
    wire ser_latch;
    logic [3:0] digit_lines_all;
    logic [6:0] seg_out;
    logic decimal_point_out;
    int miscompares = 0;
    int comparisons = 0;
    logic [11:0] outs;
    logic [11:0] frozen;
    int moved;
    ldc_row_t rows [13] = '{
        '{16'h1000, 4'hf, 2'h3, 1'b1, 1'b0, 8'h3f},
        '{16'h20a8, 4'h8, 2'h3, 1'b1, 1'b0, 8'h3f},
        '{16'h2281, 4'h8, 2'h3, 1'b1, 1'b0, 8'h06},
        '{16'h2100, 4'h8, 2'h0, 1'b1, 1'b1, 8'h81},
        '{16'h2600, 4'h8, 2'h0, 1'b1, 1'b1, 8'h81},
        '{16'h2102, 4'h8, 2'h2, 1'b1, 1'b1, 8'h81},
        '{16'h2000, 4'h0, 2'h2, 1'b1, 1'b1, 8'h81},
        '{16'h2001, 4'h1, 2'h2, 1'b1, 1'b1, 8'h81},
        '{16'h2103, 4'h1, 2'h3, 1'b1, 1'b1, 8'h81},
        '{16'h4000, 4'h1, 2'h3, 1'b0, 1'b1, 8'h81},
        '{16'h1000, 4'h1, 2'h3, 1'b1, 1'b1, 8'h81},
        '{16'h4001, 4'hf, 2'h3, 1'b0, 1'b0, 8'h00},
        '{16'h1000, 4'hf, 2'h3, 1'b1, 1'b0, 8'h3f}
    };

    always #12.5 core_clk = ~core_clk;

    assign outs = {digit_lines_all, decimal_point_out, seg_out};

    ldc_host_model i_host (
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .ser_latch(ser_latch)
    );

    ldc_config_decode #(.SLOT_CYCLES(SLOTS)) i_dut (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .core_ce(core_ce),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .ser_latch(ser_latch),
        .digit_lines_all(digit_lines_all),
        .seg_out(seg_out),
        .decimal_point_out(decimal_point_out)
    );

    task automatic finish_test();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            miscompares++;
        end
    endtask

    // counts on-cycles per digit line and the pattern under digit zero
    task automatic measure(input ldc_row_t r);
        int on_cnt [4];
        int exp_on;
        logic [7:0] seg_seen;
        string what;
        seg_seen = 8'h00;
        what = r.pass ? "segments" : "glyph";
        on_cnt = '{0, 0, 0, 0};
        repeat (WIN) begin
            @(negedge core_clk);
            for (int i = 0; i < 4; i++) begin
                if (digit_lines_all[i] === 1'b1) on_cnt[i]++;
            end
            if (digit_lines_all[0] === 1'b1) begin
                seg_seen = {decimal_point_out, seg_out};
            end
        end
        for (int i = 0; i < 4; i++) begin
            exp_on = 0;
            if (r.run && i <= r.cnt) begin
                exp_on = WIN / ((r.cnt + 1) * 16 * SLOTS) * r.duty * SLOTS;
            end
            check("digit_on", 16'(exp_on), 16'(on_cnt[i]));
        end
        if (r.run && r.duty != 4'h0) begin
            check(what, 16'(r.seg), 16'(seg_seen));
        end
    endtask

    task automatic put(input logic [15:0] w);
        i_host.send(w);
        repeat (8) @(negedge core_clk);
    endtask

    task automatic do_reset();
        @(negedge core_clk);
        sys_rst = 1'b1;
        repeat (8) @(negedge core_clk);
        check("rst_digit", 16'h0, 16'(digit_lines_all));
        check("rst_seg", 16'h0, 16'({decimal_point_out, seg_out}));
        sys_rst = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask

    initial begin
        do_reset();
        foreach (rows[k]) begin
            put(rows[k].word);
            measure(rows[k]);
        end
        put(16'h2005);
        do_reset();
        put(16'h1000);
        measure('{16'h1000, 4'hf, 2'h3, 1'b1, 1'b0, 8'h3f});
        // back-to-back words on the serial clock
        i_host.send(16'h2003);
        i_host.send(16'h2100);
        put(16'h2201);
        measure('{16'h2201, 4'h3, 2'h0, 1'b1, 1'b1, 8'h01});
        // a low enable must freeze the scan mid-frame; 40 cycles is
        // longer than one whole scan, so a running scan would show
        core_ce = 1'b0;
        @(negedge core_clk);
        frozen = outs;
        moved = 0;
        repeat (40) begin
            @(negedge core_clk);
            if (outs !== frozen) moved++;
        end
        check("ce_freeze_moves", 16'h0, 16'(moved));
        core_ce = 1'b1;
        finish_test();
    end

    // about 52 windows of scan, well above the 15 windows measured plus serial traffic
    initial begin
        #500000;
        miscompares++;
        finish_test();
    end
endmodule // ldc_config_decode_test
`default_nettype wire
